// ---- sdrc_cfg.svh ----
// Command numbers, field positions, reset values and counts of the receiver command bank.
`ifndef SDRC_CFG_SVH
`define SDRC_CFG_SVH
`define SDRC_CMD_SYS2 4'h1
`define SDRC_CMD_MCLK 4'h2
`define SDRC_CMD_SRC 4'h5
`define SDRC_CMD_DIO1 4'h6
`define SDRC_CMD_FMT 4'h7
`define SDRC_CMD_IRQ 4'h8
`define SDRC_CMD_ERR 4'h9
`define SDRC_CMD_GPIO 4'ha
`define SDRC_CMD_DIO2 4'hd
`define SDRC_RST_BYTE 8'h00
`define SDRC_SYS2_MON_BIT 3
`define SDRC_MCLK_XIN_BIT 1
`define SDRC_MCLK_AMP_LSB 6
`define SDRC_SRC_CLK_BIT 1
`define SDRC_SRC_USEL_BIT 4
`define SDRC_SRC_OVR_BIT 5
`define SDRC_SRC_MUTE_BIT 6
`define SDRC_DIO1_DEM_LSB 0
`define SDRC_DIO1_THR_LSB 4
`define SDRC_FMT_OFD_BIT 0
`define SDRC_FMT_RBCK_BIT 4
`define SDRC_FMT_RLR_BIT 5
`define SDRC_FMT_SBCK_BIT 6
`define SDRC_FMT_SLR_BIT 7
`define SDRC_ERR_ERROR_CONTENT_SELECT_BIT 0
`define SDRC_ERR_PARITY_FLAG_MODE_BIT 1
`define SDRC_ERR_FORCE_BIT 4
`define SDRC_ERR_FS_BIT 5
`define SDRC_ERR_WAIT_LSB 6
`define SDRC_GPIO_LSB 4
`define SDRC_DIO2_GP_PIN_FUNCTION_SELECT_BIT 0
`define SDRC_IRQ_ERR 0
`define SDRC_IRQ_INPUT_DETECT_IRQ_EN 1
`define SDRC_IRQ_GPIO 6
`define SDRC_AMP_CONT 2'b00
`define SDRC_AMP_AUTO 2'b10
`define SDRC_SEL_NONE 3'h7
`define SDRC_WAIT_00 5'd3
`define SDRC_WAIT_01 5'd24
`define SDRC_WAIT_10 5'd12
`define SDRC_WAIT_11 5'd6
`define SDRC_PARITY_RUN 4'd8
`endif

// ---- sdrc_pkg.sv ----
// Types shared by the receiver command bank.
package sdrc_pkg;
  typedef enum logic [1:0] {
    SDRC_ERR_UNLOCKED,
    SDRC_ERR_WAIT,
    SDRC_ERR_CLEAR
  } sdrc_err_e;
  typedef logic [7:0] sdrc_byte_t;
endpackage : sdrc_pkg

// ---- sdrc_top.sv ----
// Receiver command registers, command FIFO and the control logic they steer.
`timescale 1ns/10ps
`include "sdrc_cfg.svh"

module sdrc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : sdrc_fifo

// Operation
// - Crystal clock used while unlocked, or always when clock select is set.
// - While unlocked, data output carries serial input, or mutes if select set.
// - Override bit forces serial input onto data output regardless of lock.
// - Mute bit silences data output; otherwise source selection applies.
// - Clock source switch leaves error pin unchanged under the stated conditions.
// - R and S output clocks derive from one phase source.
// - Demodulation input picks receive input 0..6; code 7 selects none.
// - Through output 1 passes receive input 0..6; code 7 holds low.
// - Format bit selects I2S or 24-bit MSB-first left-justified.
// - Bit clock polarity bits choose falling or rising data change edge.
// - Word clock polarity bits choose left or right channel in low period.
// - Eight enable bits route their events to the interrupt output.
// - Input detect interrupt needs 24.576MHz crystal and input monitoring enabled.
// - Channel status flag raised when 48 bits match the previous block.
// - Burst Pc flag raised when 16-bit Pc matches the previous block.
// - Parallel input flag raised only on change at the 24kHz sample.
// - Error pin adds non-PCM when content bit set; non-PCM error mutes data.
// - Parity flag: up to 8 consecutive on non-PCM, or per erroneous sub-frame.
// - Force bit drives error pin high without touching data or clocks.
// - fs change bit gates fs errors; fs while amplifier stopped ignored.
// - Error clears after 3, 24, 12 or 6 block preambles; data follows.
// - Parallel output mode drives four GPIO pins from the output bits.
// - Amplifier field: 00 continuous, 10 stops while locked, 11 stopped.
module sdrc_top
  import sdrc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int RX_INPUTS = 7
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] chip_addr,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_chip,
  input wire logic [3:0] cmd_num,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_apply_ok,
  input wire logic pll_locked,
  input wire logic block_preamble,
  input wire logic data_error,
  input wire logic parity_error,
  input wire logic nonpcm_detect,
  input wire logic fs_changed,
  input wire logic cs_fs_changed,
  input wire logic [RX_INPUTS-1:0] rx_in,
  input wire logic demod_data,
  input wire logic serial_data_in,
  input wire logic bit_clock_phase,
  input wire logic word_clock_phase,
  input wire logic [3:0] gp_in,
  input wire logic gp_sample_tick,
  input wire logic gp_parallel_out_mode,
  input wire logic cs_block_done,
  input wire logic [47:0] cs_block,
  input wire logic pc_block_done,
  input wire logic [15:0] pc_block,
  input wire logic input_detect_change,
  input wire logic fs_update,
  input wire logic emphasis_detect,
  output logic demod_rx,
  output logic through_output_1,
  output logic recovered_data,
  output logic use_crystal_clock,
  output logic osc_amp_running,
  output logic output_format_select,
  output logic r_bit_clock,
  output logic r_word_clock,
  output logic s_bit_clock,
  output logic s_word_clock,
  output logic error_pin,
  output logic irq_out,
  output logic [3:0] gp_out,
  output logic [3:0] gp_out_en_n
);
  sdrc_byte_t sys2_reg;
  sdrc_byte_t mclk_reg;
  sdrc_byte_t clock_source_and_data_source;
  sdrc_byte_t data_input_and_through_select;
  sdrc_byte_t serial_output_format;
  sdrc_byte_t interrupt_source_enable;
  sdrc_byte_t error_pin_conditions;
  sdrc_byte_t general_output_pin_data;
  sdrc_byte_t dio2_reg;
  logic fifo_valid;
  logic [13:0] fifo_data;
  logic wr;
  logic [3:0] wr_num;
  sdrc_byte_t wr_byte;
  sdrc_err_e err_state;
  logic [4:0] preamble_count;
  logic [3:0] parity_run;
  logic err_core;
  logic err_pin_q;
  logic nonpcm_q;
  logic [47:0] cs_prev;
  logic [15:0] pc_prev;
  logic [3:0] gp_prev;
  logic [7:0] events;
  logic [7:0] enables;
  logic fs_err;
  logic parity_flag;

  // Commands are buffered so a burst can arrive while application waits for a safe moment.
  sdrc_fifo #(.WIDTH(14), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data({cmd_chip, cmd_num, cmd_data}),
    .out_valid(fifo_valid),
    .out_ready(cmd_apply_ok),
    .out_data(fifo_data)
  );

  assign wr_num = fifo_data[11:8];
  assign wr_byte = fifo_data[7:0];
  // Commands for another chip address are drained and dropped.
  assign wr = fifo_valid & cmd_apply_ok & (fifo_data[13:12] == chip_addr);

  function automatic logic pick_rx(input logic [2:0] code, input logic [RX_INPUTS-1:0] rx);
    pick_rx = (code == `SDRC_SEL_NONE) ? 1'b0 : rx[code];
  endfunction : pick_rx

  function automatic logic [4:0] wait_count(input logic [1:0] code);
    case (code)
      2'b00: wait_count = `SDRC_WAIT_00;
      2'b01: wait_count = `SDRC_WAIT_01;
      2'b10: wait_count = `SDRC_WAIT_10;
      default: wait_count = `SDRC_WAIT_11;
    endcase
  endfunction : wait_count

  // Test commands 11 and 15 and unused numbers are ignored.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sys2_reg <= `SDRC_RST_BYTE;
      mclk_reg <= `SDRC_RST_BYTE;
      clock_source_and_data_source <= `SDRC_RST_BYTE;
      data_input_and_through_select <= `SDRC_RST_BYTE;
      serial_output_format <= `SDRC_RST_BYTE;
      interrupt_source_enable <= `SDRC_RST_BYTE;
      error_pin_conditions <= `SDRC_RST_BYTE;
      general_output_pin_data <= `SDRC_RST_BYTE;
      dio2_reg <= `SDRC_RST_BYTE;
    end else if (wr) begin
      case (wr_num)
        `SDRC_CMD_SYS2: sys2_reg <= wr_byte;
        `SDRC_CMD_MCLK: mclk_reg <= wr_byte;
        `SDRC_CMD_SRC: clock_source_and_data_source <= wr_byte;
        `SDRC_CMD_DIO1: data_input_and_through_select <= wr_byte;
        `SDRC_CMD_FMT: serial_output_format <= wr_byte;
        `SDRC_CMD_IRQ: interrupt_source_enable <= wr_byte;
        `SDRC_CMD_ERR: error_pin_conditions <= wr_byte;
        `SDRC_CMD_GPIO: general_output_pin_data <= wr_byte;
        `SDRC_CMD_DIO2: dio2_reg <= wr_byte;
        default: ;
      endcase
    end
  end

  assign use_crystal_clock = clock_source_and_data_source[`SDRC_SRC_CLK_BIT] | ~pll_locked;

  always_comb begin
    case (mclk_reg[`SDRC_MCLK_AMP_LSB +: 2])
      `SDRC_AMP_CONT: osc_amp_running = 1'b1;
      `SDRC_AMP_AUTO: osc_amp_running = ~pll_locked;
      default: osc_amp_running = 1'b0;
    endcase
  end

  assign fs_err = ~error_pin_conditions[`SDRC_ERR_FS_BIT] &
                  ((fs_changed & osc_amp_running) | cs_fs_changed);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      parity_run <= '0;
    end else if (!parity_error) begin
      parity_run <= '0;
    end else if (parity_run != `SDRC_PARITY_RUN) begin
      parity_run <= parity_run + 1'b1;
    end
  end

  assign parity_flag = error_pin_conditions[`SDRC_ERR_PARITY_FLAG_MODE_BIT] ? parity_error :
                       (parity_error & nonpcm_detect & (parity_run != `SDRC_PARITY_RUN));

  // The clock source bit is kept out of the error term, so switching leaves it alone.
  assign err_core = data_error | parity_flag | fs_err |
                    (error_pin_conditions[`SDRC_ERR_ERROR_CONTENT_SELECT_BIT] & nonpcm_detect);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_state <= SDRC_ERR_UNLOCKED;
      preamble_count <= '0;
    end else begin
      case (err_state)
        SDRC_ERR_UNLOCKED: begin
          preamble_count <= '0;
          if (pll_locked) begin
            err_state <= SDRC_ERR_WAIT;
          end
        end
        SDRC_ERR_WAIT: begin
          if (!pll_locked) begin
            err_state <= SDRC_ERR_UNLOCKED;
          end else if (block_preamble) begin
            if (preamble_count + 1'b1 == wait_count(error_pin_conditions[`SDRC_ERR_WAIT_LSB +: 2])) begin
              err_state <= SDRC_ERR_CLEAR;
            end
            preamble_count <= preamble_count + 1'b1;
          end
        end
        SDRC_ERR_CLEAR: begin
          if (!pll_locked) begin
            err_state <= SDRC_ERR_UNLOCKED;
          end
        end
        default: err_state <= SDRC_ERR_UNLOCKED;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_pin_q <= 1'b1;
    end else begin
      err_pin_q <= (err_state != SDRC_ERR_CLEAR) | err_core |
                   error_pin_conditions[`SDRC_ERR_FORCE_BIT];
    end
  end
  assign error_pin = err_pin_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      recovered_data <= 1'b0;
    end else if (clock_source_and_data_source[`SDRC_SRC_MUTE_BIT]) begin
      recovered_data <= 1'b0;
    end else if (clock_source_and_data_source[`SDRC_SRC_OVR_BIT]) begin
      recovered_data <= serial_data_in;
    end else if (!pll_locked) begin
      recovered_data <= clock_source_and_data_source[`SDRC_SRC_USEL_BIT] ? 1'b0 : serial_data_in;
    end else begin
      recovered_data <= (err_state == SDRC_ERR_CLEAR) & ~err_core & demod_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      demod_rx <= 1'b0;
      through_output_1 <= 1'b0;
    end else begin
      demod_rx <= pick_rx(data_input_and_through_select[`SDRC_DIO1_DEM_LSB +: 3], rx_in);
      through_output_1 <= pick_rx(data_input_and_through_select[`SDRC_DIO1_THR_LSB +: 3], rx_in);
    end
  end

  assign output_format_select = serial_output_format[`SDRC_FMT_OFD_BIT];

  // Both systems share one phase source, so they cannot drift apart.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_bit_clock <= 1'b0;
      s_bit_clock <= 1'b0;
      r_word_clock <= 1'b0;
      s_word_clock <= 1'b0;
    end else begin
      r_bit_clock <= bit_clock_phase ^ serial_output_format[`SDRC_FMT_RBCK_BIT];
      s_bit_clock <= bit_clock_phase ^ serial_output_format[`SDRC_FMT_SBCK_BIT];
      r_word_clock <= word_clock_phase ^ serial_output_format[`SDRC_FMT_RLR_BIT];
      s_word_clock <= word_clock_phase ^ serial_output_format[`SDRC_FMT_SLR_BIT];
    end
  end

  // Block compares keep the last value, which resets to zero, so a first block of all zeros flags.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_prev <= '0;
      pc_prev <= '0;
      gp_prev <= '0;
      nonpcm_q <= 1'b0;
    end else begin
      nonpcm_q <= nonpcm_detect;
      if (cs_block_done) begin
        cs_prev <= cs_block;
      end
      if (pc_block_done) begin
        pc_prev <= pc_block;
      end
      if (gp_sample_tick) begin
        gp_prev <= gp_in;
      end
    end
  end

  always_comb begin
    events = '0;
    events[`SDRC_IRQ_ERR] = err_pin_q ^ ((err_state != SDRC_ERR_CLEAR) | err_core |
                            error_pin_conditions[`SDRC_ERR_FORCE_BIT]);
    events[`SDRC_IRQ_INPUT_DETECT_IRQ_EN] = input_detect_change;
    events[2] = fs_update;
    events[3] = cs_block_done & (cs_block == cs_prev);
    events[4] = nonpcm_detect ^ nonpcm_q;
    events[5] = pc_block_done & (pc_block == pc_prev);
    events[`SDRC_IRQ_GPIO] = gp_sample_tick & (gp_in != gp_prev) &
                             ~dio2_reg[`SDRC_DIO2_GP_PIN_FUNCTION_SELECT_BIT];
    events[7] = emphasis_detect;
  end

  always_comb begin
    enables = interrupt_source_enable;
    enables[`SDRC_IRQ_INPUT_DETECT_IRQ_EN] = interrupt_source_enable[`SDRC_IRQ_INPUT_DETECT_IRQ_EN] &
                               mclk_reg[`SDRC_MCLK_XIN_BIT] & sys2_reg[`SDRC_SYS2_MON_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(events & enables);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gp_out <= '0;
      gp_out_en_n <= 4'hf;
    end else begin
      gp_out <= general_output_pin_data[`SDRC_GPIO_LSB +: 4];
      gp_out_en_n <= {4{~gp_parallel_out_mode}};
    end
  end
endmodule : sdrc_top

// ---- sdrc_checker.sv ----
// Port-level assertions for the receiver command bank.
`timescale 1ns/10ps
module sdrc_checker #(
  parameter int FIFO_DEPTH = 4,
  parameter int RX_INPUTS = 7
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] chip_addr,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [1:0] cmd_chip,
  input wire logic [3:0] cmd_num,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_apply_ok,
  input wire logic pll_locked,
  input wire logic [RX_INPUTS-1:0] rx_in,
  input wire logic emphasis_detect,
  input wire logic demod_rx,
  input wire logic through_output_1,
  input wire logic recovered_data,
  input wire logic use_crystal_clock,
  input wire logic osc_amp_running,
  input wire logic output_format_select,
  input wire logic error_pin,
  input wire logic irq_out
);
  // Shadow copy of the command queue and registers, rebuilt from the command port.
  logic [13:0] q [4];
  logic [7:0] regs [16];
  logic [1:0] rp, wp;
  logic [2:0] cnt;
  wire push = cmd_valid && cmd_ready;
  wire pop = cnt != 3'h0 && cmd_apply_ok;
  wire [13:0] head = q[rp];
  wire [7:0] src_r = regs[5];
  wire [7:0] amp_r = regs[2];
  wire [7:0] dio_r = regs[6];
  wire [7:0] fmt_r = regs[7];
  wire [7:0] irq_r = regs[8];
  wire [7:0] err_r = regs[9];
  wire thr_exp = dio_r[6:4] == 3'h7 ? 1'b0 : rx_in[dio_r[6:4]];
  wire dem_exp = dio_r[2:0] == 3'h7 ? 1'b0 : rx_in[dio_r[2:0]];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= 3'h0;
      rp <= 2'h0;
      wp <= 2'h0;
      for (int i = 0; i < 16; i++) regs[i] <= 8'h00;
    end else begin
      if (push) q[wp] <= {cmd_chip, cmd_num, cmd_data};
      if (push) wp <= wp + 2'h1;
      if (pop) rp <= rp + 2'h1;
      if (pop && head[13:12] == chip_addr) regs[head[11:8]] <= head[7:0];
      cnt <= cnt + {2'h0, push} - {2'h0, pop};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ready_tracks_fill_a: assert property (cmd_ready == (cnt < FIFO_DEPTH))
    else $error("ready does not match queue fill");
  crystal_select_a: assert property (
    src_r[1] || !pll_locked |-> use_crystal_clock) else $error("crystal not selected");
  amp_running_a: assert property (
    amp_r[7:6] == 2'b00 |-> osc_amp_running) else $error("amplifier not running");
  amp_stopped_a: assert property (
    amp_r[7:6] == 2'b11 |-> !osc_amp_running) else $error("amplifier not stopped");
  format_bit_a: assert property (
    output_format_select == fmt_r[0]) else $error("format select wrong");
  through_pick_a: assert property (
    !$past(rst) |-> through_output_1 == $past(thr_exp)) else $error("through output wrong");
  demod_pick_a: assert property (
    !$past(rst) |-> demod_rx == $past(dem_exp)) else $error("demod input wrong");
  forced_error_a: assert property (
    !$past(rst) && $past(err_r[4]) |-> error_pin) else $error("error pin not forced");
  irq_routes_a: assert property (
    !$past(rst) && $past(irq_r[7] && emphasis_detect) |-> irq_out) else $error("irq missed");
  irq_quiet_a: assert property (
    !$past(rst) && $past(irq_r) == 8'h00 |-> !irq_out) else $error("irq while disabled");
  data_mute_a: assert property (
    !$past(rst) && $past(src_r[6]) |-> !recovered_data) else $error("data not muted");
  cover property (!cmd_ready);
  cover property (err_r[4] && error_pin);
  cover property (irq_out);
endmodule : sdrc_checker

// ---- sdrc_host.sv ----
// Controller model that offers commands on the command port.
`timescale 1ns/10ps
module sdrc_host (
  input wire logic core_clk,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output logic [1:0] cmd_chip,
  output logic [3:0] cmd_num,
  output logic [7:0] cmd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_chip = 2'h0;
    cmd_num = 4'h0;
    cmd_data = 8'h00;
  end
  function automatic logic [7:0] keep(input logic [3:0] num);
    case (num)
      4'h2: keep = 8'hde;
      4'h5: keep = 8'h72;
      4'h6: keep = 8'h77;
      4'h7: keep = 8'hf1;
      4'h9: keep = 8'hf3;
      4'ha: keep = 8'hf0;
      default: keep = 8'hff;
    endcase
  endfunction : keep
  task automatic send(input logic [1:0] chip, input logic [3:0] num, input logic [7:0] data);
    cmd_valid <= 1'b1;
    cmd_chip <= chip;
    cmd_num <= num;
    cmd_data <= data & keep(num);
    // Ready only moves on the rising edge, so its value mid-cycle is what the next edge sees.
    @(negedge core_clk);
    while (!cmd_ready) @(negedge core_clk);
    @(posedge core_clk);
  endtask : send
  // A released port shows inverted fields so stale values cannot pass for a command.
  task automatic release_bus;
    cmd_valid <= 1'b0;
    cmd_chip <= ~cmd_chip;
    cmd_num <= ~cmd_num;
    cmd_data <= ~cmd_data;
  endtask : release_bus
endmodule : sdrc_host

// ---- test_spdif_rx_control_commands.sv ----
// Self-checking bench for the receiver command bank.
`timescale 1ns/10ps
module test_spdif_rx_control_commands;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_apply_ok = 1'b1, pll_locked = 1'b0, block_preamble = 1'b0;
  logic nonpcm_detect = 1'b0, emphasis_detect = 1'b0, gp_parallel_out_mode = 1'b0;
  logic [15:0] fc = 16'h0000;
  logic [6:0] rx_in = 7'h00;
  logic [3:0] gp_in = 4'h0;
  logic demod_data = 1'b0, serial_data_in = 1'b0, bit_clock_phase = 1'b0;
  logic word_clock_phase = 1'b0, gp_sample_tick = 1'b0, cs_block_done = 1'b0;
  logic pc_block_done = 1'b0, input_detect_change = 1'b0, fs_update = 1'b0;
  logic [47:0] cs_block = 48'h0;
  logic [15:0] pc_block = 16'h0;
  logic cmd_valid, cmd_ready, demod_rx, through_output_1, recovered_data, use_crystal_clock;
  logic osc_amp_running, output_format_select, r_bit_clock, r_word_clock, s_bit_clock;
  logic s_word_clock, error_pin, irq_out;
  logic [1:0] cmd_chip;
  logic [3:0] cmd_num, gp_out, gp_out_en_n;
  logic [7:0] cmd_data;
  int miscompares = 0;
  int comparisons = 0;
  always #5 core_clk = ~core_clk;
  // Background traffic keeps the data and event inputs moving.
  always @(posedge core_clk) begin
    fc <= fc + 16'h1;
    {gp_in, rx_in, demod_data, serial_data_in, bit_clock_phase} <= fc[15:2] ^ fc[13:0];
    word_clock_phase <= fc[3];
    {gp_sample_tick, cs_block_done, pc_block_done, input_detect_change, fs_update} <= {5{&fc[2:0]}};
    cs_block <= {3{fc}};
    pc_block <= fc >> 4;
  end
  sdrc_top dut (.core_clk, .rst, .chip_addr(2'h1), .cmd_valid, .cmd_ready, .cmd_chip, .cmd_num,
    .cmd_data, .cmd_apply_ok, .pll_locked, .block_preamble, .data_error(1'b0),
    .parity_error(1'b0), .nonpcm_detect, .fs_changed(1'b0), .cs_fs_changed(1'b0), .rx_in,
    .demod_data, .serial_data_in, .bit_clock_phase, .word_clock_phase, .gp_in, .gp_sample_tick,
    .gp_parallel_out_mode, .cs_block_done, .cs_block, .pc_block_done, .pc_block,
    .input_detect_change, .fs_update, .emphasis_detect, .demod_rx, .through_output_1,
    .recovered_data, .use_crystal_clock, .osc_amp_running, .output_format_select, .r_bit_clock,
    .r_word_clock, .s_bit_clock, .s_word_clock, .error_pin, .irq_out, .gp_out, .gp_out_en_n);
  sdrc_host host (.core_clk, .cmd_ready, .cmd_valid, .cmd_chip, .cmd_num, .cmd_data);
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] num, input logic [7:0] data);
    @(posedge core_clk);
    host.send(2'h1, num, data);
    host.release_bus();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask : wr
  task automatic t_fifo;
    @(negedge core_clk);
    check("error_pin reset", 8'h01, error_pin);
    check("crystal unlocked", 8'h01, use_crystal_clock);
    @(posedge core_clk);
    cmd_apply_ok <= 1'b0;
    host.send(2'h1, 4'h7, 8'h00);
    host.send(2'h1, 4'h5, 8'h40);
    host.send(2'h1, 4'h7, 8'h01);
    host.send(2'h2, 4'h7, 8'h00);
    host.release_bus();
    @(negedge core_clk);
    check("cmd_ready full", 8'h00, cmd_ready);
    @(posedge core_clk);
    cmd_apply_ok <= 1'b1;
    repeat (8) @(negedge core_clk);
    check("format after drain", 8'h01, output_format_select);
    check("muted data", 8'h00, recovered_data);
  endtask : t_fifo
  task automatic t_source;
    logic [7:0] cfg [4] = '{8'h00, 8'h10, 8'h30, 8'h70};
    logic pass [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic e;
    for (int i = 0; i < 4; i++) begin
      wr(4'h5, cfg[i]);
      e = pass[i] & serial_data_in;
      @(negedge core_clk);
      check("recovered_data", e, recovered_data);
    end
  endtask : t_source
  task automatic t_select;
    logic e;
    for (int c = 0; c < 8; c++) begin
      wr(4'h6, {1'b0, c[2:0], 1'b0, c[2:0]});
      e = c == 7 ? 1'b0 : rx_in[c];
      @(negedge core_clk);
      check("through_output_1", e, through_output_1);
      check("demod_rx", e, demod_rx);
    end
  endtask : t_select
  task automatic t_format;
    logic [3:0] v [2];
    logic [1:0] ph;
    for (int p = 0; p < 2; p++) begin
      wr(4'h7, p == 1 ? 8'hf1 : 8'h00);
      ph = {bit_clock_phase, word_clock_phase};
      @(negedge core_clk);
      v[p] = {r_bit_clock, r_word_clock, s_bit_clock, s_word_clock} ^ {ph, ph};
      check("format select", p[7:0], output_format_select);
    end
    check("clock polarity", 8'h0f, v[0] ^ v[1]);
    check("r s phase", v[0][3:2], v[0][1:0]);
  endtask : t_format
  task automatic t_irq_gpio;
    wr(4'h8, 8'h80);
    @(posedge core_clk);
    emphasis_detect <= 1'b1;
    @(posedge core_clk);
    emphasis_detect <= 1'b0;
    @(negedge core_clk);
    check("irq enabled", 8'h01, irq_out);
    wr(4'h8, 8'h00);
    @(posedge core_clk);
    gp_parallel_out_mode <= 1'b1;
    wr(4'ha, 8'ha5);
    check("irq disabled", 8'h00, irq_out);
    check("gp_out", 8'h0a, gp_out);
    check("gp_out_en_n", 8'h00, gp_out_en_n);
  endtask : t_irq_gpio
  task automatic t_error;
    int n [4] = '{3, 24, 12, 6};
    for (int c = 0; c < 4; c++) begin
      @(posedge core_clk);
      pll_locked <= 1'b0;
      wr(4'h9, {c[1:0], 6'h00});
      @(posedge core_clk);
      pll_locked <= 1'b1;
      repeat (2) @(posedge core_clk);
      for (int k = 0; k < n[c]; k++) begin
        @(negedge core_clk);
        check("error_pin waiting", 8'h01, error_pin);
        @(posedge core_clk);
        block_preamble <= 1'b1;
        @(posedge core_clk);
        block_preamble <= 1'b0;
      end
      repeat (3) @(negedge core_clk);
      check("error_pin cleared", 8'h00, error_pin);
    end
    wr(4'h9, 8'h10);
    check("error forced", 8'h01, error_pin);
    wr(4'h9, 8'h00);
    check("error released", 8'h00, error_pin);
    // Clear the mute left by the source test so the non-PCM mute is what silences data.
    wr(4'h5, 8'h00);
    @(posedge core_clk);
    nonpcm_detect <= 1'b1;
    wr(4'h9, 8'h01);
    check("nonpcm error", 8'h01, error_pin);
    check("nonpcm mute", 8'h00, recovered_data);
    wr(4'h2, 8'h80);
    check("amp auto stop", 8'h00, osc_amp_running);
    wr(4'h2, 8'hc0);
    check("amp stopped", 8'h00, osc_amp_running);
    // Continuous amplifier comes first so the crystal switch keeps a live clock.
    wr(4'h2, 8'h00);
    wr(4'h5, 8'h02);
    check("crystal forced", 8'h01, use_crystal_clock);
    wr(4'h5, 8'h00);
    check("pll clock", 8'h00, use_crystal_clock);
  endtask : t_error
  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_fifo();
    $display("test fifo done");
    t_source();
    $display("test source done");
    t_select();
    $display("test select done");
    t_format();
    $display("test format done");
    t_irq_gpio();
    $display("test irq gpio done");
    t_error();
    $display("test error done");
    close_out();
  end
  // The full run needs about three hundred cycles; some sixty times that means a hang.
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    close_out();
  end
endmodule : test_spdif_rx_control_commands
bind sdrc_top sdrc_checker #(.FIFO_DEPTH(FIFO_DEPTH), .RX_INPUTS(RX_INPUTS)) chk (.core_clk,
  .rst, .chip_addr, .cmd_valid, .cmd_ready, .cmd_chip, .cmd_num, .cmd_data, .cmd_apply_ok,
  .pll_locked, .rx_in, .emphasis_detect, .demod_rx, .through_output_1, .recovered_data,
  .use_crystal_clock, .osc_amp_running, .output_format_select, .error_pin, .irq_out);
